// File: dac_serial_pkg.sv
// Types shared by the DAC serial control block
`include "dac_serial_regs.svh"
package dac_serial_pkg;
	typedef enum logic {EDGE_FALL, EDGE_RISE} dout_edge_t;
	typedef logic [`WORD_BITS-1:0] word_t;
	typedef logic [`CODE_BITS-1:0] code_t;
endpackage

// File: dac_serial_readback_and_lockout.sv
// Serial port, readback output, user output and power-down lockout of a dual DAC
`timescale 1ns/100ps
`include "dac_serial_regs.svh"

// Summary of operation
// - Serial output comes straight from the top stage of the 16-bit shifter
// - Falling-edge setting: output lags input by 16 serial clocks
// - Rising-edge setting: output lags input by 15.5 serial clocks
// - Output changes on falling or rising serial edge per selected setting
// - Falling-edge setting is selected after power-up
// - User logic output is low after power-up
// - Host sets user logic output high or low; level is held
// - Lockout low ignores every software power-down command
// - Lockout falling while powered down wakes outputs with prior values
// - Lockout wake needs no serial clock or chip-select activity
// - Power-up clears both input and both converter registers to zero
// - Word: select bit, two control bits, twelve data, zero sub-bit
// - Sample on rising serial clock while selected; act on deselect
// - Control word subcode picks update A or B, power-down A or B, output edge, user output level, or nothing
// - Power-down honoured only with lockout high; input registers kept
module dac_serial_readback_and_lockout (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic din,
	input wire logic cs_n,
	input wire logic shutdown_lockout_n,
	output logic dout,
	output logic user_logic_out,
	output dac_serial_pkg::dout_edge_t dout_edge,
	output dac_serial_pkg::code_t input_a_code,
	output dac_serial_pkg::code_t input_b_code,
	output dac_serial_pkg::code_t dac_a_code,
	output dac_serial_pkg::code_t dac_b_code,
	output logic power_down_a,
	output logic power_down_b
);
	import dac_serial_pkg::*;

	function automatic logic [2:0] field3(input word_t w, input int top);
		field3 = w[top -: 3];
	endfunction

	logic [3:0] pins_sync;
	logic sclk_s;
	logic din_s;
	logic cs_n_s;
	logic lockout_n_s;
	logic sclk_d;
	logic cs_n_d;
	logic lockout_n_d;
	word_t word;

	// Pins are asynchronous to core_clk; idle levels keep select and lockout high
	// Serial clock resets low like its delayed copy, so no false edge after reset
	pin_sync #(
		.WIDTH(4),
		.RESET_VAL(`SYNC_RESET)
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.pins({sclk, din, cs_n, shutdown_lockout_n}),
		.synced(pins_sync)
	);

	assign sclk_s = pins_sync[3];
	assign din_s = pins_sync[2];
	assign cs_n_s = pins_sync[1];
	assign lockout_n_s = pins_sync[0];

	// Delayed copies for edge detection, reset to the idle pin levels
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
			lockout_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
			lockout_n_d <= lockout_n_s;
		end
	end

	wire cs_active = ~cs_n_s;
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire cmd_strobe = cs_n_s & ~cs_n_d;
	wire lockout_fall = ~lockout_n_s & lockout_n_d;
	wire shift_en = sclk_rise & cs_active;

	serial_shifter #(
		.WIDTH(`WORD_BITS)
	) u_shifter (
		.core_clk(core_clk),
		.reset(reset),
		.shift_en(shift_en),
		.bit_in(din_s),
		.word(word)
	);

	// Word fields, MSB first
	wire [2:0] opcode = field3(word, `POS_CHANNEL_SELECT);
	wire [2:0] subcmd = field3(word, `POS_SUBCMD_TOP);
	wire edge_bit = word[`POS_EDGE_SELECT];
	code_t data;
	assign data = word[`POS_DATA_TOP:`POS_DATA_LOW];

	wire is_ctrl = cmd_strobe & (opcode == `OP_CONTROL);
	wire op_in_a = cmd_strobe & (opcode == `OP_LOAD_IN_A);
	wire op_in_b = cmd_strobe & (opcode == `OP_LOAD_IN_B);
	wire op_a_all = cmd_strobe & (opcode == `OP_LOAD_A_UPD_ALL);
	wire op_b_all = cmd_strobe & (opcode == `OP_LOAD_B_UPD_ALL);
	wire op_all_dac = cmd_strobe & (opcode == `OP_LOAD_ALL_DAC);
	wire op_upd_both = cmd_strobe & (opcode == `OP_UPDATE_BOTH);
	wire op_sd_both = cmd_strobe & (opcode == `OP_SHUTDOWN_BOTH);
	wire sub_upd_a = is_ctrl & (subcmd == `SUB_UPDATE_A);
	wire sub_upd_b = is_ctrl & (subcmd == `SUB_UPDATE_B);
	wire sub_pd_a = is_ctrl & (subcmd == `SUB_POWER_DOWN_A);
	wire sub_pd_b = is_ctrl & (subcmd == `SUB_POWER_DOWN_B);
	wire sub_user_lo = is_ctrl & (subcmd == `SUB_USER_LOW);
	wire sub_user_hi = is_ctrl & (subcmd == `SUB_USER_HIGH);
	wire sub_edge = is_ctrl & (subcmd == `SUB_EDGE_SELECT);

	// Converter register loads and which channels they start up
	wire upd_all = op_a_all | op_b_all | op_upd_both;
	wire load_dac_a = upd_all | op_all_dac | sub_upd_a;
	wire load_dac_b = upd_all | op_all_dac | sub_upd_b;
	code_t next_dac_a;
	code_t next_dac_b;
	assign next_dac_a = (op_a_all | op_all_dac) ? data : input_a_code;
	assign next_dac_b = (op_b_all | op_all_dac) ? data : input_b_code;

	// Lockout low blocks the request itself, not only its effect
	wire pd_req_a = (op_sd_both | sub_pd_a) & lockout_n_s;
	wire pd_req_b = (op_sd_both | sub_pd_b) & lockout_n_s;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			input_a_code <= `CODE_RESET;
			input_b_code <= `CODE_RESET;
		end else begin
			if (op_in_a | op_a_all) begin
				input_a_code <= data;
			end
			if (op_in_b | op_b_all) begin
				input_b_code <= data;
			end
		end
	end

	// Converter registers persist through power-down, so waking restores them
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dac_a_code <= `CODE_RESET;
			dac_b_code <= `CODE_RESET;
		end else begin
			if (load_dac_a) begin
				dac_a_code <= next_dac_a;
			end
			if (load_dac_b) begin
				dac_b_code <= next_dac_b;
			end
		end
	end

	// Lockout fall wakes on core_clk alone, no serial activity required
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			power_down_a <= `POWER_DOWN_RESET;
			power_down_b <= `POWER_DOWN_RESET;
		end else if (lockout_fall) begin
			power_down_a <= 1'b0;
			power_down_b <= 1'b0;
		end else begin
			if (pd_req_a) begin
				power_down_a <= 1'b1;
			end else if (load_dac_a) begin
				power_down_a <= 1'b0;
			end
			if (pd_req_b) begin
				power_down_b <= 1'b1;
			end else if (load_dac_b) begin
				power_down_b <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			user_logic_out <= `USER_OUT_RESET;
			dout_edge <= EDGE_FALL;
		end else begin
			if (sub_user_hi) begin
				user_logic_out <= 1'b1;
			end else if (sub_user_lo) begin
				user_logic_out <= 1'b0;
			end
			if (sub_edge) begin
				dout_edge <= edge_bit ? EDGE_RISE : EDGE_FALL;
			end
		end
	end

	// Rising setting takes the bit entering the top stage on this same edge,
	// half a serial clock ahead of the falling setting
	wire dout_rise_upd = sclk_rise & cs_active & (dout_edge == EDGE_RISE);
	wire dout_fall_upd = sclk_fall & cs_active & (dout_edge == EDGE_FALL);
	wire next_dout = dout_rise_upd ? word[`WORD_BITS-2] : word[`WORD_BITS-1];

	// Deselected: no update, so chained parts see stable data between frames
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dout <= `DOUT_RESET;
		end else if (dout_rise_upd | dout_fall_upd) begin
			dout <= next_dout;
		end
	end

	a_dout_hold_deselect: assert property (@(posedge core_clk) disable iff (reset)
		$past(cs_n_s) |-> $stable(dout))
		else $error("serial output changed while deselected");

	a_dout_fall_edge: assert property (@(posedge core_clk) disable iff (reset)
		(dout_edge == EDGE_FALL && $changed(dout)) |-> $past(sclk_fall))
		else $error("falling setting output moved off a falling edge");

	a_dout_rise_edge: assert property (@(posedge core_clk) disable iff (reset)
		(dout_edge == EDGE_RISE && $changed(dout)) |-> $past(sclk_rise))
		else $error("rising setting output moved off a rising edge");

	a_dout_fall_value: assert property (@(posedge core_clk) disable iff (reset)
		(sclk_fall && cs_active && dout_edge == EDGE_FALL) |=> dout == word[15])
		else $error("falling setting output not top stage");

	a_dout_rise_value: assert property (@(posedge core_clk) disable iff (reset)
		(sclk_rise && cs_active && dout_edge == EDGE_RISE) |=> dout == word[15])
		else $error("rising setting output not new top stage");

	a_shift_only_sel: assert property (@(posedge core_clk) disable iff (reset)
		(sclk_rise && cs_n_s) |=> $stable(word))
		else $error("shifter moved while deselected");

	a_pd_needs_lockout: assert property (@(posedge core_clk) disable iff (reset)
		($rose(power_down_a) || $rose(power_down_b)) |-> $past(lockout_n_s))
		else $error("power-down taken under lockout");

	a_wake_on_fall: assert property (@(posedge core_clk) disable iff (reset)
		lockout_fall |=> (!power_down_a && !power_down_b && $stable(dac_a_code)
			&& $stable(dac_b_code)))
		else $error("lockout fall did not wake with kept codes");

	a_user_out_static: assert property (@(posedge core_clk) disable iff (reset)
		$changed(user_logic_out) |-> $past(sub_user_hi || sub_user_lo))
		else $error("user output changed without command");

	a_reset_defaults: assert property (@(posedge core_clk) disable iff (reset)
		$past(reset) |-> (dac_a_code == 12'h000 && dac_b_code == 12'h000
			&& input_a_code == 12'h000 && input_b_code == 12'h000
			&& !user_logic_out && dout_edge == EDGE_FALL))
		else $error("state not cleared after reset");

	// Registers move only on the deselect strobe, never mid-frame
	a_inputs_on_strobe: assert property (@(posedge core_clk) disable iff (reset)
		($changed(input_a_code) || $changed(input_b_code)) |-> $past(cmd_strobe))
		else $error("input register moved without a deselect strobe");

	a_dacs_on_strobe: assert property (@(posedge core_clk) disable iff (reset)
		($changed(dac_a_code) || $changed(dac_b_code)) |-> $past(cmd_strobe))
		else $error("converter register moved without a deselect strobe");

	// A blocked request must not even start a power-down
	a_pd_blocked_lock: assert property (@(posedge core_clk) disable iff (reset)
		(cmd_strobe && !lockout_n_s) |=> (!$rose(power_down_a)
			&& !$rose(power_down_b)))
		else $error("power-down started while lockout low");

	a_pd_keeps_inputs: assert property (@(posedge core_clk) disable iff (reset)
		($rose(power_down_a) || $rose(power_down_b)) |-> ($stable(input_a_code)
			&& $stable(input_b_code)))
		else $error("input registers lost on power-down");

	a_wake_no_serial: assert property (@(posedge core_clk) disable iff (reset)
		(lockout_fall && cs_n_s) |=> (!power_down_a && !power_down_b))
		else $error("lockout wake needed serial activity");

	a_edge_on_cmd: assert property (@(posedge core_clk) disable iff (reset)
		$changed(dout_edge) |-> $past(sub_edge))
		else $error("output edge setting changed without command");

	a_user_follows_cmd: assert property (@(posedge core_clk) disable iff (reset)
		(sub_user_hi || sub_user_lo) |=> (user_logic_out == $past(sub_user_hi)))
		else $error("user output did not follow its command");

	c_edge_rise: cover property (@(posedge core_clk) disable iff (reset)
		$rose(dout_edge == EDGE_RISE));
	c_user_high: cover property (@(posedge core_clk) disable iff (reset)
		$rose(user_logic_out));
	c_power_down: cover property (@(posedge core_clk) disable iff (reset)
		$rose(power_down_a));
	c_wake: cover property (@(posedge core_clk) disable iff (reset)
		lockout_fall && (power_down_a || power_down_b));
	c_lock_blocked: cover property (@(posedge core_clk) disable iff (reset)
		cmd_strobe && !lockout_n_s && (opcode == `OP_SHUTDOWN_BOTH));
endmodule

// File: dac_serial_readback_and_lockout_bench.sv
// Self-checking bench for the converter serial port, readback, user output and lockout
`timescale 1ns/100ps
module dac_serial_readback_and_lockout_bench;
	typedef struct packed {logic [51:0] st; logic [1:0] rb; logic [15:0] w1;} note_t;
	logic core_clk, reset, start, two_words, lock, sclk, din, cs_n, busy, dout, user_logic_out;
	logic [31:0] frame, cap_f, cap_r;
	logic [11:0] ia, ib, da, db;
	logic pa, pb;
	dac_serial_pkg::dout_edge_t dout_edge;
	logic [51:0] st;
	logic [15:0] rnd;
	note_t q[$];
	note_t nt;
	event act;
	int num_errors, n_tests;
	dac_serial_readback_and_lockout dut (.core_clk(core_clk), .reset(reset), .sclk(sclk),
		.din(din), .cs_n(cs_n), .shutdown_lockout_n(lock), .dout(dout),
		.user_logic_out(user_logic_out), .dout_edge(dout_edge), .input_a_code(ia),
		.input_b_code(ib), .dac_a_code(da), .dac_b_code(db), .power_down_a(pa),
		.power_down_b(pb));
	serial_host_model host (.core_clk(core_clk), .start(start), .frame(frame),
		.two_words(two_words), .dout(dout), .sclk(sclk), .din(din), .cs_n(cs_n), .busy(busy),
		.cap_f(cap_f), .cap_r(cap_r));
	always #10 core_clk = ~core_clk;
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [51:0] apply(input logic [51:0] s, input logic [15:0] w, input logic lk);
		logic u, e, a, b;
		logic [11:0] xa, xb, ya, yb, d;
		{u, e, xa, xb, ya, yb, a, b} = s;
		d = w[12:1];
		case (w[15:13])
			3'h1: xa = d;
			3'h5: xb = d;
			3'h2: begin xa = d; ya = d; yb = xb; {a, b} = 2'h0; end
			3'h6: begin xb = d; yb = d; ya = xa; {a, b} = 2'h0; end
			3'h3: begin ya = d; yb = d; {a, b} = 2'h0; end
			3'h4: begin ya = xa; yb = xb; {a, b} = 2'h0; end
			3'h7: if (lk) {a, b} = 2'h3;
			default: case (w[12:10])
				3'h1: begin ya = xa; a = 1'b0; end
				3'h5: begin yb = xb; b = 1'b0; end
				3'h6: if (lk) a = 1'b1;
				3'h7: if (lk) b = 1'b1;
				3'h2: u = 1'b0;
				3'h3: u = 1'b1;
				3'h4: e = w[9];
				default: ;
			endcase
		endcase
		return {u, e, xa, xb, ya, yb, a, b};
	endfunction
	task automatic check(input string name, input logic [51:0] seen, input logic [51:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic note(input logic [1:0] rb, input logic [15:0] w1);
		q.push_back('{st, rb, w1});
		-> act;
		repeat (8) @(posedge core_clk);
	endtask
	task automatic send(input logic [31:0] f, input logic two);
		int i;
		@(posedge core_clk);
		start <= 1'b1;
		frame <= f;
		two_words <= two;
		@(posedge core_clk);
		start <= 1'b0;
		for (i = 0; i < 600; i++) begin
			@(posedge core_clk);
			if (busy === 1'b0) break;
		end
		if (i == 600) begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic word(input logic [15:0] w);
		send({16'h0000, w}, 1'b0);
		st = apply(st, w, lock);
		note(2'h0, 16'h0000);
	endtask
	task automatic readback(input logic [15:0] w1, input logic [1:0] mode);
		send({w1, 16'h0000}, 1'b1);
		note(mode, w1);
	endtask
	task automatic set_lock(input logic v);
		@(posedge core_clk);
		if (lock === 1'b1 && v === 1'b0) st[1:0] = 2'h0;
		lock <= v;
		repeat (2) @(posedge core_clk);
		note(2'h0, 16'h0000);
	endtask
	always begin
		@(act);
		repeat (6) @(posedge core_clk);
		nt = q.pop_front();
		check("outputs", {user_logic_out, dout_edge, ia, ib, da, db, pa, pb}, nt.st);
		if (nt.rb == 2'h1) begin
			check("readback_fall", 52'(cap_f[15:0]), 52'(nt.w1));
			check("no_change_on_rise", 52'(cap_r[15:0]), 52'(nt.w1));
		end
		if (nt.rb == 2'h2) begin
			check("readback_rise", 52'(cap_f[16:1]), 52'(nt.w1));
			check("prior_rise_value", 52'(cap_r[15:0]), 52'(nt.w1));
		end
		if (nt.rb != 2'h0) check("dout_held", 52'(dout), 52'h0);
	end
	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		start = 1'b0;
		frame = 32'h00000000;
		two_words = 1'b0;
		lock = 1'b1;
		rnd = 16'h0034;
		st = 52'h0;
		num_errors = 0;
		n_tests = 0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		note(2'h0, 16'h0000);
		$display("test reset_values done");
		rnd = lfsr(rnd);
		readback(rnd, 2'h1);
		word(16'h1200);
		rnd = lfsr(rnd);
		readback(rnd, 2'h2);
		word(16'h1000);
		$display("test readback done");
		word(16'h0C00);
		word(16'h0000);
		word(16'h0800);
		$display("test user_output done");
		word(16'hE000);
		set_lock(1'b0);
		word(16'hE000);
		word(16'h1800);
		word(16'h1C00);
		set_lock(1'b1);
		word(16'h1800);
		word(16'h1C00);
		word(16'h0400);
		word(16'h1400);
		$display("test lockout done");
		// Random words cover every opcode and every subcode except 2 and 5, with lockout toggling
		for (int k = 0; k < 48; k++) begin
			rnd = lfsr(rnd);
			if (rnd[3:1] == 3'h0) set_lock(rnd[4]);
			word({rnd[15:1], 1'b0});
		end
		$display("test random_words done");
		print_verdict();
	end
endmodule

// File: dac_serial_regs.svh
// Bit positions, command codes and reset values of the DAC serial control block
`ifndef DAC_SERIAL_REGS_SVH
`define DAC_SERIAL_REGS_SVH

`define WORD_BITS 16
`define CODE_BITS 12
`define POS_CHANNEL_SELECT 15
`define POS_CONTROL_HI 14
`define POS_CONTROL_LO 13
`define POS_DATA_TOP 12
`define POS_DATA_LOW 1
`define POS_TRAILING_SUB 0
`define POS_SUBCMD_TOP 12
`define POS_EDGE_SELECT 9

`define OP_CONTROL 3'h0
`define OP_LOAD_IN_A 3'h1
`define OP_LOAD_A_UPD_ALL 3'h2
`define OP_LOAD_ALL_DAC 3'h3
`define OP_UPDATE_BOTH 3'h4
`define OP_LOAD_IN_B 3'h5
`define OP_LOAD_B_UPD_ALL 3'h6
`define OP_SHUTDOWN_BOTH 3'h7

`define SUB_NO_OPERATION 3'h0
`define SUB_UPDATE_A 3'h1
`define SUB_USER_LOW 3'h2
`define SUB_USER_HIGH 3'h3
`define SUB_EDGE_SELECT 3'h4
`define SUB_UPDATE_B 3'h5
`define SUB_POWER_DOWN_A 3'h6
`define SUB_POWER_DOWN_B 3'h7

`define CODE_RESET 12'h000
`define WORD_RESET 16'h0000
`define USER_OUT_RESET 1'h0
`define DOUT_RESET 1'h0
`define POWER_DOWN_RESET 1'h0
`define SYNC_RESET 4'h3

`endif

// File: pin_sync.sv
// Two-stage synchroniser for a group of pins
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stage1 <= RESET_VAL;
			synced <= RESET_VAL;
		end else begin
			stage1 <= pins;
			synced <= stage1;
		end
	end
endmodule

// File: serial_host_model.sv
// Behavioural serial host that shifts frames into the converter and samples its readback
`timescale 1ns/100ps
module serial_host_model (
	input wire logic core_clk,
	input wire logic start,
	input wire logic [31:0] frame,
	input wire logic two_words,
	input wire logic dout,
	output logic sclk,
	output logic din,
	output logic cs_n,
	output logic busy,
	output logic [31:0] cap_f,
	output logic [31:0] cap_r
);
	int n;
	task automatic wait_n(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	initial begin
		sclk = 1'b0;
		din = 1'b1;
		cs_n = 1'b1;
		busy = 1'b0;
		cap_f = '0;
		cap_r = '0;
		forever begin
			@(posedge core_clk);
			if (start === 1'b1) begin
				n = two_words ? 32 : 16;
				busy <= 1'b1;
				cs_n <= 1'b0;
				for (int k = n - 1; k >= 0; k--) begin
					din <= frame[k];
					wait_n(4);
					sclk <= 1'b1;
					// One cycle after the edge the synchroniser has not yet let it through
					wait_n(1);
					cap_r <= {cap_r[30:0], dout};
					wait_n(3);
					sclk <= 1'b0;
					wait_n(1);
					cap_f <= {cap_f[30:0], dout};
					wait_n(3);
				end
				wait_n(4);
				cs_n <= 1'b1;
				// Released line must not keep showing the last bit
				din <= ~din;
				wait_n(4);
				busy <= 1'b0;
			end
		end
	end
endmodule

// File: serial_shifter.sv
// Input shift register, MSB first, shifting toward the top stage
`timescale 1ns/100ps
module serial_shifter #(
	parameter int WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic shift_en,
	input wire logic bit_in,
	output logic [WIDTH-1:0] word
);
	wire [WIDTH-1:0] next_word = {word[WIDTH-2:0], bit_in};

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			word <= '0;
		end else if (shift_en) begin
			word <= next_word;
		end
	end
endmodule
